/* rtl/pnds_consts.svh */
`ifndef PNDS_CONSTS_SVH
`define PNDS_CONSTS_SVH

// Register offsets on the 8-bit register port
`define PNDS_OFF_TRIG_SEL 8'h00
`define PNDS_OFF_MODE 8'h01
`define PNDS_OFF_XEN_HIGH 8'h02
`define PNDS_OFF_XEN_LOW 8'h03
`define PNDS_OFF_OUT_HIGH 8'h04
`define PNDS_OFF_OUT_LOW 8'h05
`define PNDS_OFF_STG_HIGH 8'h06
`define PNDS_OFF_STG_LOW 8'h07
`define PNDS_OFF_STG_HIGH_LO 8'h08
`define PNDS_OFF_STG_LOW_LO 8'h09

// Reset values
`define PNDS_RST_TRIG_SEL 8'hFF
`define PNDS_RST_MODE 8'hF0
`define PNDS_RST_ZERO 8'h00

// Field layout
`define PNDS_NOV_LSB 0
`define PNDS_SEL_W 2
`define PNDS_NIB_FILL 4'hF
`define PNDS_MASK_FULL 8'hFF
`define PNDS_MASK_UPPER 8'hF0
`define PNDS_MASK_LOWER 8'h0F
`define PNDS_READ_UNMAPPED 8'h00

`endif

/* rtl/pnds_pkg.sv */
package pnds_pkg;

    // One register-port access as seen by the block
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pnds_req_t;

    // Write bundle handed to one byte lane
    typedef struct packed {
        logic [7:0] stg_mask;
        logic out_we;
        logic [7:0] data;
    } pnds_lane_wr_t;

endpackage

/* rtl/pnds_trig.sv */
`timescale 1ns/1ps
`include "pnds_consts.svh"

module pnds_trig (
    input wire logic [7:0] trig_sel,
    input wire logic [3:0] nov,
    input wire logic [3:0] cmp_a,
    input wire logic [3:0] cmp_b,
    output logic [3:0] fire
);

    function automatic logic pick(input logic [1:0] sel,
                                  input logic nov_bit,
                                  input logic [3:0] a,
                                  input logic [3:0] b);
        pick = a[sel] | (nov_bit & b[sel]);
    endfunction

    always_comb begin
        for (int g = 0; g < 4; g++) begin
            fire[g] = pick(trig_sel[g*`PNDS_SEL_W +: `PNDS_SEL_W],
                           nov[g], cmp_a, cmp_b); // R12 R13
        end
    end

endmodule

/* rtl/pnds_lane.sv */
`timescale 1ns/1ps
`include "pnds_consts.svh"

module pnds_lane (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire pnds_pkg::pnds_lane_wr_t wr,
    input wire logic trig_hi,
    input wire logic trig_lo,
    input wire logic [7:0] xfer_en,
    output logic [7:0] staging_q,
    output logic [7:0] out_q
);

    logic [7:0] staging_d;
    logic [7:0] out_d;
    logic [7:0] copy;
    logic [7:0] cpu_mask;

    always_comb begin
        // Each nibble follows its own group's trigger
        copy = {{4{trig_hi}}, {4{trig_lo}}} & xfer_en; // R10 R14
        // Enabled output bits are not writable by software
        cpu_mask = wr.out_we ? ~xfer_en : 8'h00; // R11
        // Transfer uses the value held before any same-cycle write
        out_d = (staging_q & copy) | (wr.data & cpu_mask)
              | (out_q & ~copy & ~cpu_mask); // R8 R9 R15
        staging_d = (staging_q & ~wr.stg_mask)
                  | (wr.data & wr.stg_mask); // R1 R5
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            staging_q <= `PNDS_RST_ZERO; // R1
            out_q <= `PNDS_RST_ZERO;
        end else begin
            staging_q <= staging_d;
            out_q <= out_d;
        end
    end

endmodule

/* rtl/pnds_top.sv */
// What this block does
// R1 - Two 8-bit staging registers, reset zero, RW
// R2 - Staging address depends on shared or split triggers
// R3 - Shared high groups: whole byte one address
// R4 - Split high groups: two nibble views, two addresses
// R5 - Nibble view unused bits read one, ignore writes
// R6 - Shared low groups: whole byte one address
// R7 - Split low groups: two nibble views, two addresses
// R8 - High staging copies to high output on trigger
// R9 - Low staging copies to low output on trigger
// R10 - Copy only bits whose transfer enable is set
// R11 - Enabled output bits block software writes
// R12 - Two-bit select picks timer channel 0 to 3
// R13 - Normal uses match A; non-overlap A or B
// R14 - Split trigger copies only its own nibble
// R15 - Same-cycle write: trigger moves the old value
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "pnds_consts.svh"

module pnds_top (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] cmp_a,
    input wire logic [3:0] cmp_b,
    output logic [7:0] reg_rdata,
    output logic [7:0] pulse_out_high,
    output logic [7:0] pulse_out_low
);

    pnds_pkg::pnds_req_t req;
    pnds_pkg::pnds_lane_wr_t wr_high;
    pnds_pkg::pnds_lane_wr_t wr_low;

    logic [7:0] trigger_select_reg_q;
    logic [7:0] trigger_select_reg_d;
    logic [7:0] output_mode_reg_q;
    logic [7:0] output_mode_reg_d;
    logic [7:0] transfer_enable_high_q;
    logic [7:0] transfer_enable_high_d;
    logic [7:0] transfer_enable_low_q;
    logic [7:0] transfer_enable_low_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    logic [7:0] staging_high;
    logic [7:0] staging_low;
    logic [7:0] out_high_q;
    logic [7:0] out_low_q;
    logic [3:0] group_fire;
    logic split_high;
    logic split_low;

    function automatic logic [7:0] upper_view(input logic [7:0] b);
        upper_view = {b[7:4], `PNDS_NIB_FILL}; // R5
    endfunction

    function automatic logic [7:0] lower_view(input logic [7:0] b);
        lower_view = {`PNDS_NIB_FILL, b[3:0]}; // R5
    endfunction

    // Byte mask for a staging write at the shared or upper-view address
    function automatic logic [7:0] main_mask(input logic split);
        main_mask = split ? `PNDS_MASK_UPPER : `PNDS_MASK_FULL;
    endfunction

    // Split views read back with their reserved nibble set
    function automatic logic [7:0] main_read(input logic split,
                                             input logic [7:0] b);
        main_read = split ? upper_view(b) : b;
    endfunction

    // One driver for the whole request bundle
    assign req = {reg_addr, reg_wdata, reg_wr, reg_rd};

    // A byte splits when its two groups select different channels
    assign split_high = trigger_select_reg_q[7:6]
                     != trigger_select_reg_q[5:4]; // R2
    assign split_low = trigger_select_reg_q[3:2]
                    != trigger_select_reg_q[1:0]; // R2

    pnds_trig u_trig (
        .trig_sel(trigger_select_reg_q),
        .nov(output_mode_reg_q[`PNDS_NOV_LSB +: 4]),
        .cmp_a(cmp_a),
        .cmp_b(cmp_b),
        .fire(group_fire)
    );

    // Staging write decode
    always_comb begin
        wr_high.data = req.wdata;
        wr_high.out_we = req.wr && (req.addr == `PNDS_OFF_OUT_HIGH);
        wr_high.stg_mask = 8'h00;
        wr_low.data = req.wdata;
        wr_low.out_we = req.wr && (req.addr == `PNDS_OFF_OUT_LOW);
        wr_low.stg_mask = 8'h00;
        if (req.wr) begin
            if (req.addr == `PNDS_OFF_STG_HIGH) begin
                wr_high.stg_mask = main_mask(split_high); // R3 R4
            end
            if (req.addr == `PNDS_OFF_STG_HIGH_LO && split_high) begin
                wr_high.stg_mask = `PNDS_MASK_LOWER; // R4 R5
            end
            if (req.addr == `PNDS_OFF_STG_LOW) begin
                wr_low.stg_mask = main_mask(split_low); // R6 R7
            end
            if (req.addr == `PNDS_OFF_STG_LOW_LO && split_low) begin
                wr_low.stg_mask = `PNDS_MASK_LOWER; // R7 R5
            end
        end
    end

    // Groups 3 and 2 share the high byte, groups 1 and 0 the low byte
    pnds_lane u_lane_high (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wr(wr_high),
        .trig_hi(group_fire[3]),
        .trig_lo(group_fire[2]),
        .xfer_en(transfer_enable_high_q),
        .staging_q(staging_high),
        .out_q(out_high_q)
    ); // R8 R14

    pnds_lane u_lane_low (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wr(wr_low),
        .trig_hi(group_fire[1]),
        .trig_lo(group_fire[0]),
        .xfer_en(transfer_enable_low_q),
        .staging_q(staging_low),
        .out_q(out_low_q)
    ); // R9 R14

    // Control registers and read path
    always_comb begin
        trigger_select_reg_d = trigger_select_reg_q;
        output_mode_reg_d = output_mode_reg_q;
        transfer_enable_high_d = transfer_enable_high_q;
        transfer_enable_low_d = transfer_enable_low_q;
        rdata_d = `PNDS_READ_UNMAPPED;
        if (req.wr) begin
            unique case (req.addr)
                `PNDS_OFF_TRIG_SEL: trigger_select_reg_d = req.wdata;
                `PNDS_OFF_MODE: output_mode_reg_d = req.wdata;
                `PNDS_OFF_XEN_HIGH: transfer_enable_high_d = req.wdata;
                `PNDS_OFF_XEN_LOW: transfer_enable_low_d = req.wdata;
                default: begin
                end
            endcase
        end
        if (req.rd) begin
            unique case (req.addr)
                `PNDS_OFF_TRIG_SEL: rdata_d = trigger_select_reg_q;
                `PNDS_OFF_MODE: rdata_d = output_mode_reg_q;
                `PNDS_OFF_XEN_HIGH: rdata_d = transfer_enable_high_q;
                `PNDS_OFF_XEN_LOW: rdata_d = transfer_enable_low_q;
                `PNDS_OFF_OUT_HIGH: rdata_d = out_high_q;
                `PNDS_OFF_OUT_LOW: rdata_d = out_low_q;
                `PNDS_OFF_STG_HIGH: begin
                    rdata_d = main_read(split_high, staging_high); // R3 R4
                end
                `PNDS_OFF_STG_LOW: begin
                    rdata_d = main_read(split_low, staging_low); // R6 R7
                end
                `PNDS_OFF_STG_HIGH_LO: begin
                    // Only decoded while the byte is split
                    if (split_high) begin
                        rdata_d = lower_view(staging_high); // R4
                    end
                end
                `PNDS_OFF_STG_LOW_LO: begin
                    if (split_low) begin
                        rdata_d = lower_view(staging_low); // R7
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            trigger_select_reg_q <= `PNDS_RST_TRIG_SEL;
            output_mode_reg_q <= `PNDS_RST_MODE;
            transfer_enable_high_q <= `PNDS_RST_ZERO;
            transfer_enable_low_q <= `PNDS_RST_ZERO;
            rdata_q <= `PNDS_RST_ZERO;
        end else begin
            trigger_select_reg_q <= trigger_select_reg_d;
            output_mode_reg_q <= output_mode_reg_d;
            transfer_enable_high_q <= transfer_enable_high_d;
            transfer_enable_low_q <= transfer_enable_low_d;
            rdata_q <= rdata_d;
        end
    end

    // Inversion bits are stored for software only; the output stage
    // that applies them sits outside this block.
    assign reg_rdata = rdata_q;
    assign pulse_out_high = out_high_q;
    assign pulse_out_low = out_low_q;

endmodule

/* verification/pnds_top_monitor.sv */
`timescale 1ns/1ps
module pnds_monitor (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] cmp_a,
    input wire logic [3:0] cmp_b,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] pulse_out_high,
    input wire logic [7:0] pulse_out_low
);
    logic [7:0] sel_q;
    logic [7:0] xen_q;
    logic hi_split;
    logic lo_split;
    logic no_cmp;
    // Shadows let views and write blocking be judged from the ports alone
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sel_q <= 8'hFF;
            xen_q <= 8'h00;
        end else if (reg_wr && reg_addr == 8'h00) begin
            sel_q <= reg_wdata;
        end else if (reg_wr && reg_addr == 8'h02) begin
            xen_q <= reg_wdata;
        end
    end
    assign hi_split = sel_q[7:6] != sel_q[5:4];
    assign lo_split = sel_q[3:2] != sel_q[1:0];
    assign no_cmp = cmp_a == 4'h0 && cmp_b == 4'h0;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    property p_rd_idle;
        reg_rdata != 8'h00 |-> $past(reg_rd); endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray data");
    property p_unmap;
        reg_rd && reg_addr > 8'h09 |=> reg_rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped");
    property p_hold_hi;
        no_cmp && !(reg_wr && reg_addr == 8'h04)
        |=> $stable(pulse_out_high); endproperty
    a_hold_hi: assert property (p_hold_hi) else $error("high moved");
    property p_hold_lo;
        no_cmp && !(reg_wr && reg_addr == 8'h05)
        |=> $stable(pulse_out_low); endproperty
    a_hold_lo: assert property (p_hold_lo) else $error("low moved");
    property p_hi_up;
        reg_rd && reg_addr == 8'h06 && hi_split
        |=> reg_rdata[3:0] == 4'hF; endproperty
    a_hi_up: assert property (p_hi_up) else $error("upper view");
    property p_hi_dn;
        reg_rd && reg_addr == 8'h08 && hi_split
        |=> reg_rdata[7:4] == 4'hF; endproperty
    a_hi_dn: assert property (p_hi_dn) else $error("lower view");
    property p_lo_dn;
        reg_rd && reg_addr == 8'h09 && lo_split
        |=> reg_rdata[7:4] == 4'hF; endproperty
    a_lo_dn: assert property (p_lo_dn) else $error("low view");
    property p_no_view;
        reg_rd && reg_addr == 8'h08 && !hi_split
        |=> reg_rdata == 8'h00; endproperty
    a_no_view: assert property (p_no_view) else $error("view unsplit");
    property p_blk;
        reg_wr && reg_addr == 8'h04 && no_cmp |=>
        ((pulse_out_high ^ $past(pulse_out_high)) & xen_q) == 8'h00;
    endproperty
    a_blk: assert property (p_blk) else $error("write not blocked");
endmodule

bind pnds_top pnds_monitor u_pnds_monitor (.clk_sys(clk_sys),
    .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .cmp_a(cmp_a), .cmp_b(cmp_b),
    .reg_rdata(reg_rdata), .pulse_out_high(pulse_out_high),
    .pulse_out_low(pulse_out_low));

/* verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] cmp_a = 4'h0;
    logic [3:0] cmp_b = 4'h0;
    logic [7:0] reg_rdata;
    logic [7:0] pulse_out_high;
    logic [7:0] pulse_out_low;
    logic [7:0] pat;
    logic [7:0] eh;
    logic [1:0] cc;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    always #2 clk_sys = ~clk_sys;
    pnds_top u_pnds_top (.clk_sys(clk_sys), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .cmp_a(cmp_a), .cmp_b(cmp_b),
        .reg_rdata(reg_rdata), .pulse_out_high(pulse_out_high),
        .pulse_out_low(pulse_out_low));
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk(reg_rdata, exp);
    endtask
    // Compare pulses last one cycle; outputs are looked at mid-cycle
    task automatic fire(input logic [3:0] a, input logic [3:0] b);
        @(posedge clk_sys);
        cmp_a <= a;
        cmp_b <= b;
        @(posedge clk_sys);
        cmp_a <= 4'h0;
        cmp_b <= 4'h0;
        @(negedge clk_sys);
    endtask
    task automatic outc(input logic [7:0] h, input logic [7:0] l);
        chk(pulse_out_high, h);
        chk(pulse_out_low, l);
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            test_done;
        end
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        rdc(8'h00, 8'hFF);
        rdc(8'h01, 8'hF0);
        for (int i = 2; i < 8; i++) begin
            rdc(i[7:0], 8'h00);
        end
        wr(8'h06, 8'hA5);
        wr(8'h07, 8'h5A);
        wr(8'h20, 8'h77);
        wr(8'h08, 8'hFF);
        rdc(8'h06, 8'hA5);
        rdc(8'h07, 8'h5A);
        rdc(8'h08, 8'h00);
        rdc(8'h20, 8'h00);
        $display("test reset and shared map done");
        wr(8'h02, 8'hFF);
        wr(8'h03, 8'hFF);
        eh = 8'h00;
        for (int c = 0; c < 4; c++) begin
            cc = c[1:0];
            pat = 8'h3C ^ {4{cc}};
            wr(8'h00, {4{cc}});
            wr(8'h06, pat);
            wr(8'h07, ~pat);
            fire(4'h1 << (cc + 2'h1), 4'h1 << cc);
            outc(eh, ~eh ^ {8{c == 0}});
            fire(4'h1 << cc, 4'h0);
            outc(pat, ~pat);
            eh = pat;
        end
        wr(8'h01, 8'hFF);
        wr(8'h06, 8'h81);
        wr(8'h07, 8'h18);
        fire(4'h0, 4'h8);
        outc(8'h81, 8'h18);
        wr(8'h01, 8'hF0);
        $display("test trigger select done");
        wr(8'h02, 8'hF0);
        wr(8'h03, 8'h0F);
        wr(8'h06, 8'hFF);
        wr(8'h07, 8'hFF);
        fire(4'h8, 4'h0);
        outc(8'hF1, 8'h1F);
        wr(8'h04, 8'h00);
        wr(8'h05, 8'h00);
        rdc(8'h04, 8'hF0);
        rdc(8'h05, 8'h0F);
        $display("test enables done");
        wr(8'h02, 8'hFF);
        wr(8'h03, 8'hFF);
        wr(8'h00, 8'h1B);
        wr(8'h06, 8'hA5);
        wr(8'h08, 8'h3C);
        wr(8'h07, 8'h5A);
        wr(8'h09, 8'hC3);
        rdc(8'h06, 8'hAF);
        rdc(8'h08, 8'hFC);
        rdc(8'h07, 8'h5F);
        rdc(8'h09, 8'hF3);
        rdc(8'h00, 8'h1B);
        fire(4'h1, 4'h0);
        outc(8'hA0, 8'h0F);
        fire(4'h2, 4'h0);
        outc(8'hAC, 8'h0F);
        fire(4'h4, 4'h0);
        outc(8'hAC, 8'h5F);
        fire(4'h8, 4'h0);
        outc(8'hAC, 8'h53);
        $display("test split views done");
        wr(8'h00, 8'hFF);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= 8'h06;
        reg_wdata <= 8'h42;
        cmp_a <= 4'h8;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        cmp_a <= 4'h0;
        @(negedge clk_sys);
        chk(pulse_out_high, 8'hAC);
        fire(4'h8, 4'h0);
        chk(pulse_out_high, 8'h42);
        $display("test write with trigger done");
        test_done;
    end
endmodule
